// ===== rtmc_bc_model.sv
module rtmc_bc_model
   import rtmc_pkg::*;
#(
   parameter bit RESTRICT = 1'b0
) (
   // clock and status answer
   input  wire logic        clk_sys,
   input  wire logic        rspValid,
   input  wire logic [15:0] rspWord,
   // command to the terminal
   output logic             cmdValid,
   output logic             cmdMsgErr,
   output logic             cmdBroadcast,
   output logic             cmdBus,
   output logic [4:0]       cmdSubaddr,
   output logic [4:0]       cmdCount,
   output logic             txStatusDone
);
   logic [15:0] lastRsp = 16'h0000;
   int          rspCnt  = 0;
   int          slowCyc = 0;
   int          dly     = 0;
   initial begin
      {cmdValid, cmdMsgErr, cmdBroadcast, cmdBus, txStatusDone} = 5'h00;
      cmdSubaddr = 5'h0a;
      cmdCount = 5'h15;
   end
   // any mode code can go out; the restricted profile never sends bus control
   task automatic send(input logic [4:0] sa, input logic [4:0] mc, input logic brd,
                       input logic err, input logic bus);
      if (RESTRICT && mc == MC_DBC) return;
      @(posedge clk_sys);
      cmdSubaddr <= sa;
      cmdCount <= mc;
      cmdBroadcast <= brd;
      cmdMsgErr <= err;
      cmdBus <= bus;
      cmdValid <= 1'b1;
      @(posedge clk_sys);
      cmdValid <= 1'b0;
      // released field lines must not keep the last value
      cmdSubaddr <= ~sa;
      cmdCount <= ~mc;
   endtask : send
   // status word takes slowCyc + 1 cycles on the wire before its parity point
   always @(posedge clk_sys) begin
      txStatusDone <= (dly == 1);
      if (rspValid === 1'b1) begin
         lastRsp <= rspWord;
         rspCnt <= rspCnt + 1;
         dly <= slowCyc + 1;
      end else if (dly > 0) begin
         dly <= dly - 1;
      end
   end
endmodule : rtmc_bc_model

// ===== rtmc_core.sv
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
module rtmc_core #(
   parameter int unsigned RESET_CYCLES    = rtmc_pkg::RST_CYC,
   parameter int unsigned SELFTEST_CYCLES = rtmc_pkg::ST_CYC
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // axi4-lite slave
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // decoded command from the word receiver
   input  wire logic        cmdValid,
   input  wire logic        cmdMsgErr,
   input  wire logic        cmdBroadcast,
   input  wire logic        cmdBus,
   input  wire logic [4:0]  cmdSubaddr,
   input  wire logic [4:0]  cmdCount,
   input  wire logic [4:0]  rtAddr,
   // word transmitter handshake
   input  wire logic        txStatusDone,
   output logic             rspValid,
   output logic [15:0]      rspWord,
   output logic             txOffA,
   output logic             txOffB,
   // subsystem side
   input  wire logic        ssFault,
   input  wire logic        selfTestFail,
   output logic             resetActive,
   output logic             selfTestActive
);
   import rtmc_pkg::*;

   typedef enum logic [2:0] {
      MC_IDLE,
      MC_WAIT_RST,
      MC_RESETTING,
      MC_WAIT_ST,
      MC_TESTING
   } rtmc_state_t;

   typedef struct packed {
      rtmc_state_t       st;
      logic              meBit;
      logic              bcrBit;
      logic              dbcaBit;
      logic              tfBit;
      logic              txOffA;
      logic              txOffB;
      logic              rstAct;
      logic              stAct;
      logic              rspValid;
      logic [15:0]       rspWord;
      logic [CTRL_W-1:0] ctrl;
      logic              awGot;
      logic [7:0]        awAddr;
      logic              wGot;
      logic [31:0]       wData;
      logic [3:0]        wStrb;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
   } rtmc_core_t;

   rtmc_core_t core_reg;
   rtmc_core_t core_next;
   logic       rstDone;
   logic       stDone;
   // timers are started in the cycle the state changes, so no extra cycle is lost
   logic       rstStart;
   logic       stStart;
   logic       stAbort;

   function automatic logic isModeCmd(input logic [4:0] sa);
      return (sa == SA_MODE_LO) || (sa == SA_MODE_HI);
   endfunction : isModeCmd

   // reserved and instrumentation positions are never written, so they stay zero
   function automatic logic [15:0] buildStatus(input logic [4:0] addr, input logic me,
                                               input logic srq, input logic bcr,
                                               input logic busy, input logic ssf,
                                               input logic dbca, input logic tf);
      logic [15:0] w;
      w                           = 16'h0000;
      w[SW_ADDR_LSB +: 5]         = addr;
      w[SW_ME]                    = me;
      w[SW_SRQ]                   = srq;
      w[SW_BCR]                   = bcr;
      w[SW_BUSY]                  = busy;
      w[SW_SSF]                   = ssf;
      w[SW_DBCA]                  = dbca;
      w[SW_TF]                    = tf;
      return w;
   endfunction : buildStatus

   rtmc_timer #(
      .CYC (RESET_CYCLES)
   ) u_rst_timer (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .start   (rstStart),
      .abort   (1'b0),
      .running (),
      .done    (rstDone)
   );

   rtmc_timer #(
      .CYC (SELFTEST_CYCLES)
   ) u_st_timer (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .start   (stStart),
      .abort   (stAbort),
      .running (),
      .done    (stDone)
   );

   always_comb begin
      logic        ssf;
      logic        busy;
      logic        bcOk;
      logic [31:0] rd;
      core_next          = core_reg;
      ssf                = ssFault & core_reg.ctrl[CTRL_SS_EN];
      bcOk               = ~cmdBroadcast | core_reg.ctrl[CTRL_BC_EN];
      busy               = 1'b0;
      rd                 = 32'h0000_0000;
      core_next.rspValid = 1'b0;
      rstStart           = 1'b0;
      stStart            = 1'b0;
      stAbort            = 1'b0;

      // completion of timed operations
      if (core_reg.st == MC_RESETTING && rstDone) begin
         core_next.st = MC_IDLE;
      end
      if (core_reg.st == MC_TESTING && stDone) begin
         core_next.st    = MC_IDLE;
         core_next.tfBit = selfTestFail;
      end
      // the timed operation starts only once our status word has left
      if (txStatusDone && core_reg.st == MC_WAIT_RST) begin
         core_next.st       = MC_RESETTING;
         rstStart           = 1'b1;
      end
      if (txStatusDone && core_reg.st == MC_WAIT_ST) begin
         core_next.st      = MC_TESTING;
         stStart           = 1'b1;
      end

      if (cmdValid && bcOk) begin
         if (cmdMsgErr) begin
            // no answer to a faulty message, only the flag
            core_next.meBit = 1'b1;
         end else if (core_reg.st == MC_RESETTING) begin
            // status-only busy answer: no data word can leave mid reset
            if (!cmdBroadcast) begin
               core_next.rspValid = 1'b1;
            end
         end else begin
            if (core_reg.st == MC_TESTING || core_reg.st == MC_WAIT_ST) begin
               core_next.st      = MC_IDLE;
               stAbort           = 1'b1;
            end
            if (!(isModeCmd(cmdSubaddr) && cmdCount == MC_TXSTATUS)) begin
               core_next.meBit   = 1'b0;
               core_next.bcrBit  = cmdBroadcast;
               core_next.dbcaBit = 1'b0;
            end
            if (isModeCmd(cmdSubaddr)) begin
               case (cmdCount)
                  MC_SHUTDOWN: begin
                     if (cmdBus) begin
                        core_next.txOffA = 1'b1;
                     end else begin
                        core_next.txOffB = 1'b1;
                     end
                  end
                  MC_OVERRIDE: begin
                     if (cmdBus) begin
                        core_next.txOffA = 1'b0;
                     end else begin
                        core_next.txOffB = 1'b0;
                     end
                  end
                  MC_RESET: begin
                     // a broadcast gets no status word, so reset begins at once
                     if (cmdBroadcast) begin
                        core_next.st       = MC_RESETTING;
                        rstStart           = 1'b1;
                     end else begin
                        core_next.st = MC_WAIT_RST;
                     end
                  end
                  MC_SELFTEST: begin
                     if (core_reg.ctrl[CTRL_ST_EN]) begin
                        if (cmdBroadcast) begin
                           core_next.st      = MC_TESTING;
                           stStart           = 1'b1;
                        end else begin
                           core_next.st = MC_WAIT_ST;
                        end
                     end
                  end
                  MC_DBC: begin
                     if (core_reg.ctrl[CTRL_DBC_EN] && !cmdBroadcast) begin
                        core_next.dbcaBit = 1'b1;
                     end
                  end
                  default: begin
                  end
               endcase
            end
            core_next.rspValid = ~cmdBroadcast;
         end
      end

      // reset start clears both transmitter shutdowns, the dynamic bus control acceptance bit and the terminal flag
      if (rstStart) begin
         core_next.txOffA  = 1'b0;
         core_next.txOffB  = 1'b0;
         core_next.dbcaBit = 1'b0;
         core_next.tfBit   = 1'b0;
      end
      core_next.rstAct = (core_next.st == MC_RESETTING);
      core_next.stAct  = (core_next.st == MC_TESTING);
      // busy only while commanded reset runs or with a subsystem fault flag
      busy = core_next.rstAct | ssf;
      if (core_next.rspValid) begin
         core_next.rspWord = buildStatus(rtAddr, core_next.meBit,
                                         core_reg.ctrl[CTRL_SRQ],
                                         core_next.bcrBit, busy, ssf,
                                         core_next.dbcaBit, core_next.tfBit);
      end

      // axi write channel
      if (core_reg.bvalid && bready) begin
         core_next.bvalid = 1'b0;
      end
      if (awvalid && core_reg.awready) begin
         core_next.awGot  = 1'b1;
         core_next.awAddr = awaddr;
      end
      if (wvalid && core_reg.wready) begin
         core_next.wGot  = 1'b1;
         core_next.wData = wdata;
         core_next.wStrb = wstrb;
      end
      if (core_next.awGot && core_next.wGot && !core_next.bvalid) begin
         core_next.awGot  = 1'b0;
         core_next.wGot   = 1'b0;
         core_next.bvalid = 1'b1;
         core_next.bresp  = RESP_OKAY;
         if (core_next.awAddr == OFS_CTRL) begin
            if (core_next.wStrb[0]) begin
               core_next.ctrl = core_next.wData[CTRL_W-1:0];
            end
         end else if (core_next.awAddr == OFS_STATUS || core_next.awAddr == OFS_STATE) begin
            core_next.bresp = RESP_OKAY;
         end else begin
            core_next.bresp = RESP_SLVERR;
         end
      end
      core_next.awready = ~core_next.awGot & ~core_next.bvalid;
      core_next.wready  = ~core_next.wGot & ~core_next.bvalid;

      // axi read channel
      if (core_reg.rvalid && rready) begin
         core_next.rvalid = 1'b0;
      end
      if (arvalid && core_reg.arready) begin
         core_next.rvalid = 1'b1;
         core_next.rresp  = RESP_OKAY;
         if (araddr == OFS_CTRL) begin
            rd[CTRL_W-1:0] = core_reg.ctrl;
         end else if (araddr == OFS_STATUS) begin
            rd[15:0] = buildStatus(rtAddr, core_reg.meBit, core_reg.ctrl[CTRL_SRQ],
                                   core_reg.bcrBit, core_reg.rstAct | ssf, ssf,
                                   core_reg.dbcaBit, core_reg.tfBit);
         end else if (araddr == OFS_STATE) begin
            rd[4:0] = {core_reg.txOffB, core_reg.txOffA, core_reg.tfBit,
                       core_reg.stAct, core_reg.rstAct};
         end else begin
            core_next.rresp = RESP_SLVERR;
         end
         core_next.rdata = rd;
      end
      core_next.arready = ~core_next.rvalid;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         core_reg <= '0;
      end else begin
         core_reg <= core_next;
      end
   end

   assign awready        = core_reg.awready;
   assign wready         = core_reg.wready;
   assign bvalid         = core_reg.bvalid;
   assign bresp          = core_reg.bresp;
   assign arready        = core_reg.arready;
   assign rvalid         = core_reg.rvalid;
   assign rresp          = core_reg.rresp;
   assign rdata          = core_reg.rdata;
   assign rspValid       = core_reg.rspValid;
   assign rspWord        = core_reg.rspWord;
   assign txOffA         = core_reg.txOffA;
   assign txOffB         = core_reg.txOffB;
   assign resetActive    = core_reg.rstAct;
   assign selfTestActive = core_reg.stAct;

   // helper counters for the deadline checks
   logic [TMR_W:0] rstRun;
   logic [TMR_W:0] stRun;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rstRun <= '0;
         stRun  <= '0;
      end else begin
         rstRun <= core_reg.rstAct ? rstRun + (TMR_W+1)'(1) : '0;
         stRun  <= core_reg.stAct ? stRun + (TMR_W+1)'(1) : '0;
      end
   end

   chk_reset_deadline: assert property (@(posedge clk_sys) disable iff (sys_rst)
      rstRun <= (TMR_W+1)'(RESET_CYCLES + 1))
      else $error("reset ran past its deadline");

   chk_selftest_deadline: assert property (@(posedge clk_sys) disable iff (sys_rst)
      stRun <= (TMR_W+1)'(SELFTEST_CYCLES + 1))
      else $error("self-test ran past its deadline");

   chk_status_first: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(core_reg.rstAct) |-> $past(txStatusDone) || $past(cmdValid && cmdBroadcast))
      else $error("reset began before status word was sent");

   chk_busy_in_reset: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (rspValid && resetActive) |-> rspWord[SW_BUSY])
      else $error("answer during reset lacks busy");

   chk_zero_bits: assert property (@(posedge clk_sys) disable iff (sys_rst)
      rspValid |-> (rspWord[SW_INSTR] == 1'b0) && (rspWord[SW_RSV_LSB +: 3] == 3'h0))
      else $error("instrumentation or reserved bit set");

   chk_msg_error: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (cmdValid && cmdMsgErr && !cmdBroadcast) |=> core_reg.meBit && !rspValid)
      else $error("message error not flagged");

   chk_abort_test: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (selfTestActive && cmdValid && !cmdMsgErr && !cmdBroadcast) |=> !selfTestActive)
      else $error("self-test not aborted by command");

   chk_busy_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (rspValid && rspWord[SW_BUSY]) |-> resetActive || $past(ssFault))
      else $error("busy without a cause");

   chk_shutdown_hi: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (cmdValid && !cmdMsgErr && !cmdBroadcast && !resetActive && cmdSubaddr == SA_MODE_HI
       && cmdCount == MC_SHUTDOWN) |=> ($past(cmdBus) ? txOffA : txOffB))
      else $error("shutdown via upper mode marker ignored");
endmodule : rtmc_core

// ===== rtmc_pkg.sv
// What this block does
// - Decode transmit status, transmitter shutdown, override shutdown and reset terminal mode codes.
// - Subaddress 00000 and 11111 both mark a mode command, with identical function.
// - On reset mode command send the status word first, then begin reset.
// - During reset answer valid commands with silence, busy status or normal response.
// - Data words sent during reset carry valid content only.
// - Reset completes within 5.0 ms after the status word parity bit.
// - Optional self-test: send status word first, then start self-test.
// - A later valid command may abort a running self-test.
// - During self-test answer valid commands with silence, busy status or normal response.
// - Data words sent during self-test carry valid content only.
// - Self-test completes with results ready within 100.0 ms after the status word.
// - The status word holds valid contents always, from power-up onward.
// - The message error status bit is implemented.
// - Instrumentation bit and reserved status bits are always zero.
// - Service request bit is optional; here software sets it.
// - Broadcast support requires the broadcast command received bit.
// - Subsystem self-test capability requires the subsystem flag bit.
// - Dynamic bus control support requires the acceptance bit.
// - Terminal self-test capability requires the terminal flag bit.
// - Conditions affecting bus communication are reported through the busy bit.
// - Busy only from specific commands, or together with a fault flag.
package rtmc_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_STATE  = 8'h08;
   // control register fields
   localparam int CTRL_W      = 5;
   localparam int CTRL_SRQ    = 0;
   localparam int CTRL_DBC_EN = 1;
   localparam int CTRL_BC_EN  = 2;
   localparam int CTRL_ST_EN  = 3;
   localparam int CTRL_SS_EN  = 4;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
   // status word field positions
   localparam int SW_ADDR_LSB = 11;
   localparam int SW_ME       = 10;
   localparam int SW_INSTR    = 9;
   localparam int SW_SRQ      = 8;
   localparam int SW_RSV_LSB  = 5;
   localparam int SW_BCR      = 4;
   localparam int SW_BUSY     = 3;
   localparam int SW_SSF      = 2;
   localparam int SW_DBCA     = 1;
   localparam int SW_TF       = 0;
   // mode command markers and codes
   localparam logic [4:0] SA_MODE_LO  = 5'h00;
   localparam logic [4:0] SA_MODE_HI  = 5'h1f;
   localparam logic [4:0] MC_DBC      = 5'h00;
   localparam logic [4:0] MC_TXSTATUS = 5'h02;
   localparam logic [4:0] MC_SELFTEST = 5'h03;
   localparam logic [4:0] MC_SHUTDOWN = 5'h04;
   localparam logic [4:0] MC_OVERRIDE = 5'h05;
   localparam logic [4:0] MC_RESET    = 5'h08;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // deadlines, longest times so counts round down
   localparam int  CLK_PERIOD_NS   = 100;
   localparam real RST_TIME_MS     = 5.0;
   localparam real ST_TIME_MS      = 100.0;
   localparam int  RST_CYC         = int'($floor(RST_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
   localparam int  ST_CYC          = int'($floor(ST_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
   localparam int  TMR_W           = 20;
endpackage : rtmc_pkg

// ===== rtmc_timer.sv
module rtmc_timer #(
   parameter int unsigned CYC = 16
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   // control
   input  wire logic start,
   input  wire logic abort,
   // state
   output logic      running,
   output logic      done
);
   import rtmc_pkg::*;

   typedef struct packed {
      logic [TMR_W-1:0] cnt;
      logic             run;
      logic             done;
   } rtmc_tmr_t;

   rtmc_tmr_t tmr_reg;
   rtmc_tmr_t tmr_next;

   always_comb begin
      tmr_next      = tmr_reg;
      tmr_next.done = 1'b0;
      // a restart in the abort cycle must win, or the new run would never finish
      if (start) begin
         tmr_next.run = 1'b1;
         tmr_next.cnt = TMR_W'(CYC - 1);
      end else if (abort) begin
         tmr_next.run = 1'b0;
      end else if (tmr_reg.run) begin
         if (tmr_reg.cnt == '0) begin
            tmr_next.run  = 1'b0;
            tmr_next.done = 1'b1;
         end else begin
            tmr_next.cnt = tmr_reg.cnt - TMR_W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         tmr_reg <= '0;
      end else begin
         tmr_reg <= tmr_next;
      end
   end

   assign running = tmr_reg.run;
   assign done    = tmr_reg.done;
endmodule : rtmc_timer

// ===== tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import rtmc_pkg::*;
   localparam int RC = 20;
   localparam int SC = 40;
   logic        clk_sys = 1'b0, sys_rst = 1'b1, ssFault = 1'b0, selfTestFail = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  wstrb = 4'hf;
   logic [4:0]  rtAddr = 5'h0b, cmdSubaddr, cmdCount;
   logic [1:0]  bresp, rresp;
   logic        awready, wready, bvalid, arready, rvalid, rspValid, txOffA, txOffB;
   logic        cmdValid, cmdMsgErr, cmdBroadcast, cmdBus, txStatusDone;
   logic        resetActive, selfTestActive;
   logic [15:0] rspWord;
   int          miscompares = 0, checks = 0, cyc = 0, t0, t1;
   rtmc_core #(.RESET_CYCLES(RC), .SELFTEST_CYCLES(SC)) u_dut (
      .clk_sys, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .cmdValid, .cmdMsgErr, .cmdBroadcast, .cmdBus, .cmdSubaddr, .cmdCount, .rtAddr,
      .txStatusDone, .rspValid, .rspWord, .txOffA, .txOffB, .ssFault, .selfTestFail,
      .resetActive, .selfTestActive);
   rtmc_bc_model u_bc (.clk_sys, .rspValid, .rspWord, .cmdValid, .cmdMsgErr, .cmdBroadcast,
      .cmdBus, .cmdSubaddr, .cmdCount, .txStatusDone);
   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) cyc <= cyc + 1;
   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic tmo(input int n);
      if (n >= 400) begin
         miscompares++;
         report_and_stop();
      end
   endtask : tmo
   // f = {me, srq, bcr, busy, ssf, dbca, tf}; instrumentation and reserved stay zero
   function automatic logic [15:0] sw(input logic [6:0] f);
      return {rtAddr, f[6], 1'b0, f[5], 3'b000, f[4:0]};
   endfunction : sw
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n = 0;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 400);
      tmo(n);
      bready <= 1'b0;
      cmp(bresp, er);
   endtask : axw
   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n = 0;
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 400);
      tmo(n);
      rready <= 1'b0;
      cmp(rdata, ed);
      cmp(rresp, er);
   endtask : axr
   // answer shows one cycle after the command is taken
   task automatic mc(input logic [4:0] sa, input logic [4:0] code, input logic brd,
                     input logic err, input logic bus, input int nAns);
      int c0 = u_bc.rspCnt;
      u_bc.send(sa, code, brd, err, bus);
      repeat (2) @(posedge clk_sys);
      cmp(u_bc.rspCnt - c0, nAns);
   endtask : mc
   task automatic waitLvl(input bit st, input logic v, output int at);
      int n = 0;
      while (((st ? selfTestActive : resetActive) !== v) && n < 400) begin
         @(posedge clk_sys);
         n++;
      end
      tmo(n);
      at = cyc;
   endtask : waitLvl
   initial begin
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      axr(OFS_STATUS, {16'h0, sw(7'h00)}, RESP_OKAY);
      axr(8'h0c, 32'h0, RESP_SLVERR);
      axw(8'h0c, 32'h1f, RESP_SLVERR);
      axw(OFS_CTRL, 32'h1f, RESP_OKAY);
      axr(OFS_CTRL, 32'h1f, RESP_OKAY);
      for (int k = 0; k < 2; k++) begin
         mc(k ? SA_MODE_HI : SA_MODE_LO, MC_TXSTATUS, 0, 0, k[0], 1);
         cmp(u_bc.lastRsp, sw(7'h20));
         mc(k ? SA_MODE_HI : SA_MODE_LO, MC_SHUTDOWN, 0, 0, k[0], 1);
         cmp({txOffA, txOffB}, k ? 2'b10 : 2'b01);
         mc(k ? SA_MODE_LO : SA_MODE_HI, MC_OVERRIDE, 0, 0, k[0], 1);
         cmp({txOffA, txOffB}, 2'b00);
      end
      mc(SA_MODE_LO, MC_TXSTATUS, 0, 1, 0, 0);
      mc(SA_MODE_LO, MC_TXSTATUS, 0, 0, 0, 1);
      cmp(u_bc.lastRsp, sw(7'h60));
      mc(SA_MODE_LO, MC_DBC, 0, 0, 0, 1);
      mc(SA_MODE_HI, MC_TXSTATUS, 0, 0, 0, 1);
      cmp(u_bc.lastRsp, sw(7'h22));
      mc(SA_MODE_HI, MC_OVERRIDE, 1, 0, 0, 0);
      mc(SA_MODE_LO, MC_TXSTATUS, 0, 0, 0, 1);
      cmp(u_bc.lastRsp, sw(7'h30));
      ssFault <= 1'b1;
      mc(SA_MODE_LO, MC_TXSTATUS, 0, 0, 0, 1);
      cmp(u_bc.lastRsp & 16'h000c, 16'h000c);
      ssFault <= 1'b0;
      mc(SA_MODE_LO, MC_TXSTATUS, 0, 0, 0, 1);
      cmp(u_bc.lastRsp & 16'h000c, 16'h0000);
      u_bc.slowCyc = 200;
      mc(SA_MODE_HI, MC_RESET, 0, 0, 0, 1);
      u_bc.slowCyc = 0;
      cmp(resetActive, 1'b0);
      waitLvl(1'b0, 1'b1, t0);
      mc(SA_MODE_LO, MC_TXSTATUS, 0, 0, 0, 1);
      cmp(u_bc.lastRsp & 16'h0008, 16'h0008);
      axr(OFS_STATE, 32'h1, RESP_OKAY);
      waitLvl(1'b0, 1'b0, t1);
      cmp(t1 - t0, RC + 1);
      selfTestFail <= 1'b1;
      mc(SA_MODE_LO, MC_SELFTEST, 0, 0, 0, 1);
      cmp(selfTestActive, 1'b0);
      waitLvl(1'b1, 1'b1, t0);
      waitLvl(1'b1, 1'b0, t1);
      cmp(t1 - t0, SC + 1);
      axr(OFS_STATE, 32'h4, RESP_OKAY);
      mc(SA_MODE_LO, MC_TXSTATUS, 0, 0, 0, 1);
      cmp(u_bc.lastRsp, sw(7'h21));
      mc(SA_MODE_HI, MC_SELFTEST, 0, 0, 0, 1);
      waitLvl(1'b1, 1'b1, t0);
      mc(SA_MODE_HI, MC_TXSTATUS, 0, 0, 0, 1);
      cmp(u_bc.lastRsp & 16'h0008, 16'h0000);
      cmp(selfTestActive, 1'b0);
      report_and_stop();
   end
endmodule : tb
